// [rwc_map.svh]
// Register offsets, field positions, reset values and timing counts of the reset and watchdog controller.
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH

// Word index of the watchdog control register; the byte address is four times this.
`define RWC_CTL_IDX       10'h093
// Field positions inside the watchdog control register.
`define RWC_PER_LSB       0
`define RWC_CLK_LSB       2
`define RWC_NMI_BIT       4
`define RWC_FLAG_BIT      5
`define RWC_EN_BIT        7
// Value of the writable fields after any system reset.
`define RWC_CTL_RESET     8'h00
// Reset-mode hold time in system clock cycles.
`define RWC_HOLD_CYC      11'd1025
// Consecutive low samples of the reset pin that start a reset.
`define RWC_EXT_LOW_CYC   2'd3
// Consecutive high samples of the reset pin that end a prolonged reset.
`define RWC_PIN_HIGH_CYC  3'd4

`endif

// [rwc_pkg.sv]
// Types shared by the reset and watchdog controller.
`default_nettype none
package rwc_pkg;

  // Reset sequencer states, one-hot.
  typedef enum logic [3:0] {
    RWC_ST_RUN  = 4'b0001,
    RWC_ST_SRC  = 4'b0010,
    RWC_ST_HOLD = 4'b0100,
    RWC_ST_WAIT = 4'b1000
  } rwc_state_t;

  // Watchdog clock select codes.
  typedef enum logic [1:0] {
    RWC_WCLK_SYS = 2'h0,
    RWC_WCLK_RTC = 2'h1,
    RWC_WCLK_RC  = 2'h2,
    RWC_WCLK_RSV = 2'h3
  } rwc_wclk_t;

  // Internal reset sources other than power-on and the watchdog.
  typedef struct packed {
    logic brownout_detect;
    logic rtc_alarm;
    logic cpu_sleep;
    logic debug_reset;
  } rwc_srcs_t;

  // Controls handed to the rest of the chip while system reset is active.
  typedef struct packed {
    logic hold_cpu;
    logic clear_pc;
    logic gpio_as_input;
    logic clk_sel_xtal;
  } rwc_sysctl_t;

endpackage
`default_nettype wire

// [rwc_top.sv]
// Reset sequencer with attached watchdog and classic Wishbone register slave.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.svh"

// Behaviour
// - Reset restores defaults, inputs GPIO, clears PC.
// - No instruction execution during system reset.
// - Reset on POR, brownout, pin, watchdog, alarm, debug.
// - Hold reset for 1025 system clock cycles.
// - Internal source: count starts after source deasserts.
// - Pin low three cycles starts the count.
// - Crystal selected as system clock during reset.
// - Drive reset pin low until timer expires.
// - Early pin release: run right after expiry.
// - Late release: run after four high samples.
// - Reset disables watchdog; bit 7 enables it.
// - Control writes ignored once watchdog enabled.
// - Period field [1:0], clock field [3:2].
// - System clock periods 2^27,2^25,2^22,2^18.
// - RTC periods 2^17,2^14,2^11,2^7.
// - RC periods 2^15,2^13,2^9,2^5.
// - Timeout gives reset or NMI; reset default.
// - Reset-mode timeout sets the reset-cause flag.
module rwc_top #(
  parameter int WD_W      = 27,  // Width of the watchdog counter, enough for the longest period.
  parameter int SYS_EXP0  = 27,  // Period exponents for the system clock.
  parameter int SYS_EXP1  = 25,
  parameter int SYS_EXP2  = 22,
  parameter int SYS_EXP3  = 18,
  parameter int RTC_EXP0  = 17,  // Period exponents for the RTC oscillator.
  parameter int RTC_EXP1  = 14,
  parameter int RTC_EXP2  = 11,
  parameter int RTC_EXP3  = 7,
  parameter int RC_EXP0   = 15,  // Period exponents for the internal RC oscillator.
  parameter int RC_EXP1   = 13,
  parameter int RC_EXP2   = 9,
  parameter int RC_EXP3   = 5
) (
  input  wire logic               clk_i,            // System clock, 50 MHz.
  input  wire logic               rst_i,            // Power-on reset, synchronous, active high.
  input  wire rwc_pkg::rwc_srcs_t srcs_i,           // Internal reset sources.
  input  wire logic               rtc_clk_i,        // RTC oscillator level.
  input  wire logic               rc_clk_i,         // Internal RC oscillator level.
  input  wire logic               reset_pin_n_i,    // Level seen on the shared reset pin.
  output logic                    reset_pin_n_o,    // Value driven onto the reset pin.
  output logic                    reset_pin_oe_n_o, // Low while the pin is driven.
  output rwc_pkg::rwc_sysctl_t    sysctl_o,         // Reset controls to the rest of the chip.
  output logic                    nmi_o,            // Non-maskable interrupt pulse.
  input  wire logic               wb_cyc_i,         // Wishbone cycle.
  input  wire logic               wb_stb_i,         // Wishbone strobe.
  input  wire logic               wb_we_i,          // Wishbone write enable.
  input  wire logic [11:0]        wb_adr_i,         // Wishbone byte address.
  input  wire logic [3:0]         wb_sel_i,         // Wishbone byte selects.
  input  wire logic [31:0]        wb_dat_i,         // Wishbone write data.
  output logic [31:0]             wb_dat_o,         // Wishbone read data.
  output logic                    wb_ack_o          // Wishbone acknowledge.
);

  // Sequencer state and its counters.
  rwc_pkg::rwc_state_t state_r;       // Current sequencer state.
  rwc_pkg::rwc_state_t state_nxt;     // Next sequencer state.
  logic [10:0]         hold_cnt_r;    // Cycles spent in the hold state.
  logic [1:0]          low_cnt_r;     // Consecutive low samples of the pin while running.
  logic [2:0]          high_cnt_r;    // Consecutive high samples of the pin while waiting.
  logic                wait_first_r;  // First cycle of the wait state.

  // Watchdog control fields.
  logic [1:0]          period_r;      // Timeout period select.
  rwc_pkg::rwc_wclk_t  wclk_r;        // Watchdog clock select.
  logic                nmi_sel_r;     // Timeout raises NMI instead of reset.
  logic                wd_en_r;       // Watchdog enable, write-once.
  logic                rst_flag_r;    // Last reset came from the watchdog.
  logic [WD_W-1:0]     wd_cnt_r;      // Watchdog tick counter.
  logic                rtc_d_r;       // Previous RTC level for edge detection.
  logic                rc_d_r;        // Previous RC level for edge detection.
  logic                wd_to_rst_r;   // Watchdog reset request, one cycle.
  logic                nmi_r;         // NMI pulse register.
  logic                ack_r;         // Bus acknowledge.
  logic [31:0]         dat_r;         // Bus read data.

  // State decodes.
  wire st_run  = (state_r == rwc_pkg::RWC_ST_RUN);
  wire st_src  = (state_r == rwc_pkg::RWC_ST_SRC);
  wire st_hold = (state_r == rwc_pkg::RWC_ST_HOLD);
  wire st_wait = (state_r == rwc_pkg::RWC_ST_WAIT);
  wire in_rst  = !st_run;

  // Brownout, debug, the watchdog request, or an alarm during sleep keeps the sequencer waiting while asserted.
  wire int_act = srcs_i.brownout_detect | srcs_i.debug_reset | wd_to_rst_r
               | (srcs_i.rtc_alarm & srcs_i.cpu_sleep);
  // The third consecutive low sample of the pin starts an external reset.
  wire ext_go  = st_run && !reset_pin_n_i && (low_cnt_r == (`RWC_EXT_LOW_CYC - 2'd1));
  wire hold_end = st_hold && (hold_cnt_r == (`RWC_HOLD_CYC - 11'd1));
  wire pin_done = reset_pin_n_i && (wait_first_r
                || (high_cnt_r == (`RWC_PIN_HIGH_CYC - 3'd1)));

  // Bus decode; the single register sits at one word, other words read zero.
  wire       bus_req  = wb_cyc_i && wb_stb_i;
  wire       ctl_hit  = (wb_adr_i[11:2] == `RWC_CTL_IDX);
  wire       ctl_wr   = bus_req && ack_r && wb_we_i && ctl_hit && wb_sel_i[0] && st_run;
  wire       ctl_load = ctl_wr && !wd_en_r;
  wire [7:0] ctl_rd   = {wd_en_r, 1'b0, rst_flag_r, nmi_sel_r, wclk_r, period_r};

  // Watchdog tick selection; the reserved clock code never ticks.
  wire wd_tick = (wclk_r == rwc_pkg::RWC_WCLK_SYS) ? 1'b1
               : (wclk_r == rwc_pkg::RWC_WCLK_RTC) ? (rtc_clk_i & ~rtc_d_r)
               : (wclk_r == rwc_pkg::RWC_WCLK_RC)  ? (rc_clk_i & ~rc_d_r)
               : 1'b0;

  // Period exponent from clock and period selects.
  function automatic int wd_exp(input logic [1:0] clk_sel, input logic [1:0] per);
    int e;
    e = SYS_EXP0;
    unique case (clk_sel)
      2'h0: e = (per == 2'h0) ? SYS_EXP0 : (per == 2'h1) ? SYS_EXP1
              : (per == 2'h2) ? SYS_EXP2 : SYS_EXP3;
      2'h1: e = (per == 2'h0) ? RTC_EXP0 : (per == 2'h1) ? RTC_EXP1
              : (per == 2'h2) ? RTC_EXP2 : RTC_EXP3;
      2'h2: e = (per == 2'h0) ? RC_EXP0 : (per == 2'h1) ? RC_EXP1
              : (per == 2'h2) ? RC_EXP2 : RC_EXP3;
      2'h3: e = WD_W;
    endcase
    return e;
  endfunction

  // Terminal count is one less than two to the selected exponent.
  wire [WD_W:0]   wd_lim_w = ({{WD_W{1'b0}}, 1'b1} << wd_exp(wclk_r, period_r)) - {{WD_W{1'b0}}, 1'b1};
  wire [WD_W-1:0] wd_lim   = wd_lim_w[WD_W-1:0];
  wire            wd_to    = st_run && wd_en_r && wd_tick && (wd_cnt_r == wd_lim);

  // Next-state logic of the sequencer.
  // A new internal event restarts the sequence from any state, since the hold
  // must count from the last source to deassert.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      rwc_pkg::RWC_ST_RUN:
      begin
        if (int_act)
          state_nxt = rwc_pkg::RWC_ST_SRC;
        else if (ext_go)
          state_nxt = rwc_pkg::RWC_ST_HOLD;
      end
      rwc_pkg::RWC_ST_SRC:
      begin
        if (!int_act)
          state_nxt = rwc_pkg::RWC_ST_HOLD;
      end
      rwc_pkg::RWC_ST_HOLD:
      begin
        if (int_act)
          state_nxt = rwc_pkg::RWC_ST_SRC;
        else if (hold_end)
          state_nxt = rwc_pkg::RWC_ST_WAIT;
      end
      rwc_pkg::RWC_ST_WAIT:
      begin
        if (int_act)
          state_nxt = rwc_pkg::RWC_ST_SRC;
        else if (pin_done)
          state_nxt = rwc_pkg::RWC_ST_RUN;
      end
      default: state_nxt = rwc_pkg::RWC_ST_SRC;
    endcase
  end

  // Sequencer state; power-on parks it waiting for the power-on source to go.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= rwc_pkg::RWC_ST_SRC;
    else
      state_r <= state_nxt;
  end

  // Hold counter runs only in the hold state and restarts on every entry.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !st_hold || int_act)
      hold_cnt_r <= 11'h000;
    else
      hold_cnt_r <= hold_cnt_r + 11'h001;
  end

  // Pin sample counters; the low count only matters while running because
  // during reset the pin is our own drive and tells nothing.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !st_run || reset_pin_n_i)
      low_cnt_r <= 2'h0;
    else if (low_cnt_r != `RWC_EXT_LOW_CYC)
      low_cnt_r <= low_cnt_r + 2'h1;
    if (rst_i || !st_wait || !reset_pin_n_i)
      high_cnt_r <= 3'h0;
    else if (high_cnt_r != `RWC_PIN_HIGH_CYC)
      high_cnt_r <= high_cnt_r + 3'h1;
    wait_first_r <= !rst_i && hold_end && !int_act;
  end

  // Watchdog control register. Writes land only at the acknowledging edge and
  // only while enable is clear; any system reset returns it to defaults.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || in_rst)
    begin
      period_r  <= 2'(`RWC_CTL_RESET >> `RWC_PER_LSB);
      wclk_r    <= rwc_pkg::RWC_WCLK_SYS;
      nmi_sel_r <= 1'b0;
      wd_en_r   <= 1'b0;
    end
    else if (ctl_load)
    begin
      period_r  <= wb_dat_i[`RWC_PER_LSB +: 2];
      wclk_r    <= rwc_pkg::rwc_wclk_t'(wb_dat_i[`RWC_CLK_LSB +: 2]);
      nmi_sel_r <= wb_dat_i[`RWC_NMI_BIT];
      wd_en_r   <= wb_dat_i[`RWC_EN_BIT];
    end
  end

  // Reset-cause flag survives the reset it reports, so the watchdog's own
  // request must not clear it. Power-on, or another source that starts a reset from run, clears it,
  // but a reset-mode watchdog timeout in the same cycle wins.
  always_ff @(posedge clk_i)
  begin
    if (wd_to && !nmi_sel_r)
      rst_flag_r <= 1'b1;
    else if (rst_i || (st_run && !wd_to_rst_r && (int_act || ext_go)))
      rst_flag_r <= 1'b0;
  end

  // Watchdog counter and its timeout actions.
  always_ff @(posedge clk_i)
  begin
    rtc_d_r <= rtc_clk_i;
    rc_d_r  <= rc_clk_i;
    if (rst_i || in_rst || !wd_en_r || wd_to)
      wd_cnt_r <= '0;
    else if (wd_tick)
      wd_cnt_r <= wd_cnt_r + {{(WD_W-1){1'b0}}, 1'b1};
    wd_to_rst_r <= !rst_i && wd_to && !nmi_sel_r;
    nmi_r       <= !rst_i && wd_to && nmi_sel_r;
  end

  // Wishbone slave: one wait state, ack for one cycle, zero for unmapped words.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req && !ack_r;
      dat_r <= ctl_hit ? {24'h00_0000, ctl_rd} : 32'h0000_0000;
    end
  end

  // Outputs. The pin drive follows the state register so it never glitches.
  assign reset_pin_n_o          = 1'b0;
  assign reset_pin_oe_n_o       = !(st_src || st_hold);
  assign sysctl_o.hold_cpu      = in_rst;
  assign sysctl_o.clear_pc      = in_rst;
  assign sysctl_o.gpio_as_input = in_rst;
  assign sysctl_o.clk_sel_xtal  = in_rst;
  assign nmi_o                  = nmi_r;
  assign wb_ack_o               = ack_r;
  assign wb_dat_o               = dat_r;

  // The hold lasts exactly its count before the pin is released.
  property p_hold_len;
    @(posedge clk_i) disable iff (rst_i)
    (st_hold && hold_cnt_r == 11'd1024 && !int_act) |=> (st_wait && reset_pin_oe_n_o);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold did not end at 1025 cycles");

  // Hold always starts from a zero count.
  property p_hold_start;
    @(posedge clk_i) disable iff (rst_i)
    $rose(st_hold) |-> (hold_cnt_r == 11'd0) && !reset_pin_oe_n_o;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold began with stale count");

  // The CPU is held and the crystal selected whenever not running.
  property p_no_exec;
    @(posedge clk_i) disable iff (rst_i)
    !st_run |-> (sysctl_o.hold_cpu && sysctl_o.clk_sel_xtal && sysctl_o.clear_pc);
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("CPU free during reset");

  // Three low samples while running start the hold.
  property p_ext_start;
    @(posedge clk_i) disable iff (rst_i)
    (st_run && !reset_pin_n_i && !int_act)[*3] |=> st_hold;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external reset not taken");

  // An internal source that goes away moves on to the hold next edge.
  property p_int_start;
    @(posedge clk_i) disable iff (rst_i)
    (st_src && !int_act) |=> st_hold;
  endproperty
  a_int_start: assert property (p_int_start) else $error("hold did not follow source");

  // Four high samples end a prolonged wait.
  property p_wait4;
    @(posedge clk_i) disable iff (rst_i)
    (st_wait && !wait_first_r ##1 (st_wait && reset_pin_n_i && !int_act)[*4]) |=> st_run;
  endproperty
  a_wait4: assert property (p_wait4) else $error("run not resumed after four highs");

  // Once enabled, a control write changes nothing.
  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    (st_run && wd_en_r && ctl_wr) |=> ($stable(ctl_rd[4:0]) && wd_en_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked control register changed");

  // Any reset leaves the watchdog disabled.
  property p_wd_off;
    @(posedge clk_i) disable iff (rst_i)
    !st_run |=> !wd_en_r;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog alive through reset");

  // A reset-mode timeout sets the flag and enters reset.
  property p_to_rst;
    @(posedge clk_i) disable iff (rst_i)
    (wd_to && !nmi_sel_r) |=> (rst_flag_r && !nmi_o) ##1 (st_src && rst_flag_r);
  endproperty
  a_to_rst: assert property (p_to_rst) else $error("watchdog reset not raised");

  // An NMI-mode timeout raises NMI and keeps running.
  property p_to_nmi;
    @(posedge clk_i) disable iff (rst_i)
    (wd_to && nmi_sel_r) |=> (nmi_o && !wd_to_rst_r && $stable(rst_flag_r)) ##1 st_run;
  endproperty
  a_to_nmi: assert property (p_to_nmi) else $error("watchdog NMI wrong");

endmodule // rwc_top
`default_nettype wire

// [rwc_pin_partner.sv]
// Behavioural model of the external reset circuitry that shares the open-drain reset pin.
`timescale 1ns/1ps
`default_nettype none
module rwc_pin_partner (
  input  wire logic        clk_i,      // System clock.
  input  wire logic        go_i,       // Starts one pull-low pulse.
  input  wire logic [11:0] len_i,      // Pulse length in clock cycles.
  input  wire logic        dev_val_i,  // Value the device puts on the pin.
  input  wire logic        dev_oe_n_i, // Low while the device drives the pin.
  output logic             pin_n_o     // Resolved pin level.
);
  logic [11:0] left_r = 12'h000; // Pull-low cycles still to go.

  // A fresh request restarts the pulse; the length is chosen by the bench, so it can break the minimum.
  always @(posedge clk_i)
  begin
    if (go_i)
      left_r <= len_i;
    else if (left_r != 12'h000)
      left_r <= left_r - 12'h001;
  end

  // Wired-AND with a pull-up, so a released pin reads high and never keeps an old value.
  assign pin_n_o = (dev_oe_n_i ? 1'b1 : dev_val_i) & (left_r == 12'h000);
endmodule // rwc_pin_partner
`default_nettype wire

// [test_reset_and_watchdog_control.sv]
// Self-checking testbench of the reset and watchdog controller.
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_watchdog_control;
  typedef struct { logic [7:0] ctl; int e; int t; } rwc_row_t; // Control value, exponent, cycles a tick.
  logic                 clk_i, rst_i, rtc_clk_i, rc_clk_i;   // Clock, reset and oscillator levels.
  rwc_pkg::rwc_srcs_t   srcs_i;                              // Internal reset sources.
  rwc_pkg::rwc_sysctl_t sysctl;                              // Reset controls seen at the outputs.
  logic                 pin_n, pin_val, oe_n, nmi, ext_go;   // Reset pin and interrupt.
  logic [11:0]          ext_len, adr;                        // Pulse length and bus address.
  logic                 cyc, stb, we, ack;                   // Bus handshake.
  logic [3:0]           sel;                                 // Byte selects.
  logic [31:0]          dat_w, dat_r, rd;                    // Bus data.
  int                   n_errors = 0, n_tests = 0, cycles = 0, n, lo, hi;
  logic [3:0]           pats [4] = '{4'b1000, 4'b0110, 4'b0001, 4'b0100}; // Source patterns.
  localparam logic [11:0] CTL = 12'h24C;                     // Byte address of the control register.
  // System clock exponents are shortened and the counter is cut to 8 bits, so any longer period
  // stops at 2^8 ticks; the shortest oscillator exponents keep their real values of 7 and 5.
  rwc_row_t rows [13] = '{'{8'h90, 6, 1}, '{8'h91, 5, 1}, '{8'h92, 4, 1}, '{8'h93, 3, 1},
                          '{8'h94, 8, 4}, '{8'h95, 8, 4}, '{8'h96, 8, 4}, '{8'h97, 7, 4},
                          '{8'h98, 8, 8}, '{8'h99, 8, 8}, '{8'h9A, 8, 8}, '{8'h9B, 5, 8}, '{8'h9C, 0, 0}};
  localparam int WAIT_LIM = 2200;  // Longest watchdog wait, above 2^8 ticks of 8 cycles each.

  rwc_top #(.WD_W(8), .SYS_EXP0(6), .SYS_EXP1(5), .SYS_EXP2(4), .SYS_EXP3(3)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .srcs_i(srcs_i), .rtc_clk_i(rtc_clk_i), .rc_clk_i(rc_clk_i),
    .reset_pin_n_i(pin_n), .reset_pin_n_o(pin_val), .reset_pin_oe_n_o(oe_n), .sysctl_o(sysctl),
    .nmi_o(nmi), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack));

  rwc_pin_partner ext (.clk_i(clk_i), .go_i(ext_go), .len_i(ext_len), .dev_val_i(pin_val),
                       .dev_oe_n_i(oe_n), .pin_n_o(pin_n));

  // Free-running 50 MHz system clock.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Slow oscillators of 4 and 8 cycles, plus the hang limit well above the expected run length.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    rtc_clk_i <= cycles[1];
    rc_clk_i <= cycles[2];
    if (cycles == 60000)
    begin
      n_errors++;
      end_of_test;
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Checks that a measured cycle count lies in a window.
  task automatic rng(input string name, input int v, input int lo, input int hi);
    check(name, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  // One classic Wishbone cycle, held until ack is sampled high.
  // Only the bench's cycle limit ends a wait that never sees ack.
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    sel <= 4'hF;
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("ack", ack, 32'h1);
  endtask

  // Counts cycles until the processor is let go, bounded.
  task automatic run_wait(output int c);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end while (sysctl.hold_cpu !== 1'b0 && c < 3000);
  endtask

  // Short power-on reset in mid-run.
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Asks the partner for one pull-low pulse, then waits for reset to begin.
  task automatic pin_pulse(input logic [11:0] len, output int c);
    ext_len <= len;
    ext_go <= 1'b1;
    @(posedge clk_i);
    ext_go <= 1'b0;
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end while (sysctl.hold_cpu !== 1'b1 && c < 12);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: power-on, table of watchdog settings, then the awkward cases.
  initial
  begin
    rst_i = 1'b1;
    srcs_i = '0;
    ext_go = 1'b0;
    ext_len = 12'h000;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat_w = 32'h00000000;
    repeat (12) @(posedge clk_i);
    check("sysctl_in_reset", sysctl, 32'hF);
    check("pin_in_reset", oe_n, 32'h0);
    rst_i <= 1'b0;
    run_wait(n);
    rng("hold_len", n, 1025, 1030);
    check("pin_after", oe_n, 32'h1);
    wb(1'b0, CTL, 8'h00, rd);
    check("ctl_reset", rd, 32'h0);
    wb(1'b0, 12'h100, 8'h00, rd);
    check("unmapped", rd, 32'h0);
    // Every clock and period code in interrupt mode; the lock and the quiet flag come with each row.
    foreach (rows[i])
    begin
      do_reset;
      run_wait(n);
      wb(1'b1, CTL, rows[i].ctl, rd);
      n = 0;
      while (nmi !== 1'b1 && n < WAIT_LIM)
      begin
        @(posedge clk_i);
        n++;
      end
      if (rows[i].t == 0)
        check("reserved_quiet", n, WAIT_LIM);
      else
      begin
        lo = (1 << rows[i].e) * rows[i].t - rows[i].t;
        hi = (1 << rows[i].e) * rows[i].t + rows[i].t + 4;
        rng("nmi_delay", n, lo, hi);
        @(posedge clk_i);
        check("nmi_pulse", nmi, 32'h0);
      end
      wb(1'b1, CTL, 8'h00, rd);
      wb(1'b0, CTL, 8'h00, rd);
      check("ctl_locked", rd, {24'h000000, rows[i].ctl});
      check("no_reset", sysctl.hold_cpu, 32'h0);
    end
    // Watchdog in reset mode: reset follows, the cause flag survives and the enable is cleared.
    do_reset;
    run_wait(n);
    wb(1'b1, CTL, 8'h83, rd);
    n = 0;
    while (sysctl.hold_cpu !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    rng("wd_reset_delay", n, 7, 14);
    check("wd_pin", oe_n, 32'h0);
    check("wd_no_nmi", nmi, 32'h0);
    run_wait(n);
    wb(1'b0, CTL, 8'h00, rd);
    check("flag_set", rd, 32'h20);
    // External pin: two low cycles are ignored, three start reset, a long hold needs four highs.
    pin_pulse(12'd2, n);
    check("short_pin", sysctl.hold_cpu, 32'h0);
    pin_pulse(12'd3, n);
    rng("pin_start", n, 3, 6);
    run_wait(n);
    rng("pin_early", n, 1024, 1030);
    pin_pulse(12'd1500, n);
    n = 0;
    while (pin_n !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    run_wait(n);
    rng("pin_late", n, 3, 6);
    // Internal sources; an alarm outside sleep must not reset.
    foreach (pats[i])
    begin
      srcs_i <= rwc_pkg::rwc_srcs_t'(pats[i]);
      repeat (20) @(posedge clk_i);
      check("src_reset", sysctl.hold_cpu, 32'(i != 3));
      check("src_pin", oe_n, 32'(i == 3));
      srcs_i <= '0;
      run_wait(n);
      if (i != 3)
        rng("src_hold", n, 1025, 1030);
    end
    end_of_test;
  end
endmodule // test_reset_and_watchdog_control
`default_nettype wire
